// >>> common/lpx_pkg.sv
package lpx_pkg;
  localparam logic [3:0] LPX_ADDR_CMD_STATUS = 4'h0;
  localparam logic [3:0] LPX_ADDR_CONTROL = 4'h4;
  localparam logic [3:0] LPX_ADDR_PHASE = 4'h8;
  localparam logic [3:0] LPX_ADDR_EVENT = 4'hC;
  localparam int LPX_BIT_CONFLICT = 15;
  localparam int LPX_BIT_PENDING = 14;
  localparam int LPX_BIT_PARAM = 13;
  localparam int LPX_CODE_HI = 12;
  localparam int LPX_CODE_LO = 8;
  localparam int LPX_BIT_LOST = 7;
  localparam int LPX_BIT_IND_VALID = 6;
  localparam int LPX_REASON_HI = 5;
  localparam int LPX_REASON_LO = 4;
  localparam int LPX_IND_HI = 3;
  localparam int LPX_IND_LO = 0;
  localparam int LPX_BIT_TX_OFF = 0;
  localparam int LPX_BIT_RX_OFF = 1;
  localparam int LPX_BIT_INT_EN = 2;
  localparam logic [15:0] LPX_CSR_RESET = 16'h0000;
  localparam logic [4:0] LPX_CMD_STOP = 5'h00;
  localparam logic [4:0] LPX_CMD_START = 5'h01;
  localparam logic [4:0] LPX_CMD_CONNECT = 5'h02;
  localparam logic [4:0] LPX_CMD_RESET = 5'h04;
  localparam logic [1:0] LPX_RESP_OKAY = 2'h0;
  localparam logic [1:0] LPX_RESP_SLVERR = 2'h2;
  localparam logic [2:0] LPX_SWRST_CYCLES = 3'h4;
  typedef enum logic [1:0]
  {
    LPX_STOPPED = 2'b00,
    LPX_DISCONNECTED = 2'b01,
    LPX_INFO_XFER = 2'b11,
    LPX_TRANSPARENT = 2'b10
  } lpx_phase_t;
endpackage

// >>> hw/lpx_primitive_exchange.sv
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - set conflict flag bit 15 when a command clashes with current phase
// - conflict flag clears only by write-one, bus reset or software reset
// - host sets pending bit 14; device clears it after processing; reset clears
// - connect/reset with parameter 0 retransmits unacknowledged frames
// - connect/reset with parameter 1 discards frames and returns descriptors
// - stop enters stopped phase: dma halts, transmitter idles ones, rx ignored
// - stop during a frame aborts it by driving ones at once
// - stop with parameter 1 performs full software reset
// - start with parameter 0 resets rings, enters disconnected, sends flags
// - start with parameter 1 enters information transfer directly
// - start accepted only when stopped or transparent, else conflict
// - indication valid set by device, cleared by write-one or reset
// - two-bit reason in bits 5:4 accompanies certain indications
// - disconnect reasons are passed through from the protocol engine
// - reset, error and busy reasons are passed through likewise
// - indication code bits 3:0 written together with valid flag
// - every indication update sets the indication interrupt flag
// - start enables rings unless disabled; stop disables both rings
module lpx_primitive_exchange
  import lpx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ind_strobe,
  input wire logic [3:0] ind_code,
  input wire logic [1:0] ind_reason,
  input wire logic ind_lost,
  input wire logic transparent_req,
  input wire logic tx_in_frame,
  output logic [1:0] link_phase,
  output logic dma_halt,
  output logic tx_force_ones,
  output logic tx_abort,
  output logic rx_ignore,
  output logic ring_reset,
  output logic tx_ring_enabled,
  output logic rx_ring_enabled,
  output logic retransmit_unacked,
  output logic discard_unacked,
  output logic soft_reset,
  output logic indication_interrupt_flag
);
  logic user_cmd_conflict_flag, next_user_cmd_conflict_flag;
  logic user_cmd_pending, next_user_cmd_pending;
  logic user_cmd_param, next_user_cmd_param;
  logic [4:0] user_cmd_code, next_user_cmd_code;
  logic provider_ind_lost, next_provider_ind_lost;
  logic provider_ind_valid, next_provider_ind_valid;
  logic [1:0] provider_ind_reason, next_provider_ind_reason;
  logic [3:0] provider_ind_code, next_provider_ind_code;
  logic tx_ring_off, next_tx_ring_off, rx_ring_off, next_rx_ring_off, int_enable, next_int_enable;
  lpx_phase_t phase, next_phase;
  logic next_tx_ring, next_rx_ring, next_int_flag;
  logic next_ring_reset, next_retx, next_discard, next_tx_abort;
  logic [2:0] swrst_cnt, next_swrst_cnt;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [3:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid_q, next_bvalid, rvalid_q, next_rvalid;
  logic [1:0] bresp_q, next_bresp, rresp_q, next_rresp;
  logic [31:0] rdata_q, next_rdata;
  logic wr_fire, soft_rst_n;
  logic [15:0] csr_view;

  function automatic logic addr_mapped(input logic [3:0] a);
    addr_mapped = (a == LPX_ADDR_CMD_STATUS) || (a == LPX_ADDR_CONTROL) ||
                  (a == LPX_ADDR_PHASE) || (a == LPX_ADDR_EVENT);
  endfunction

  assign soft_rst_n = aresetn && (swrst_cnt == 3'h0);
  assign wr_fire = aw_held && w_held && !bvalid_q;
  assign csr_view = {user_cmd_conflict_flag, user_cmd_pending, user_cmd_param, user_cmd_code,
                     provider_ind_lost, provider_ind_valid, provider_ind_reason, provider_ind_code};

  // bus slave: address and data taken in either order, one write and one read at a time
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid_q;
    next_bresp = bresp_q;
    next_rvalid = rvalid_q;
    next_rresp = rresp_q;
    next_rdata = rdata_q;
    if (s_axi_awvalid && !aw_held)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = addr_mapped(aw_addr) ? LPX_RESP_OKAY : LPX_RESP_SLVERR;
    end
    else if (bvalid_q && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_q)
    begin
      next_rvalid = 1'b1;
      next_rresp = addr_mapped(s_axi_araddr) ? LPX_RESP_OKAY : LPX_RESP_SLVERR;
      unique case (s_axi_araddr)
        LPX_ADDR_CMD_STATUS: next_rdata = {16'h0000, csr_view};
        LPX_ADDR_CONTROL: next_rdata = {29'h0, int_enable, rx_ring_off, tx_ring_off};
        LPX_ADDR_PHASE: next_rdata = {26'h0, rx_ring_enabled, tx_ring_enabled, 2'h0, phase};
        LPX_ADDR_EVENT: next_rdata = {31'h0, indication_interrupt_flag};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    else if (rvalid_q && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= LPX_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= LPX_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid_q <= next_bvalid;
      bresp_q <= next_bresp;
      rvalid_q <= next_rvalid;
      rresp_q <= next_rresp;
      rdata_q <= next_rdata;
    end
  end

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // command register, interpreter and indication capture
  always_comb
  begin
    next_user_cmd_conflict_flag = user_cmd_conflict_flag;
    next_user_cmd_pending = user_cmd_pending;
    next_user_cmd_param = user_cmd_param;
    next_user_cmd_code = user_cmd_code;
    next_provider_ind_lost = provider_ind_lost;
    next_provider_ind_valid = provider_ind_valid;
    next_provider_ind_reason = provider_ind_reason;
    next_provider_ind_code = provider_ind_code;
    next_tx_ring_off = tx_ring_off;
    next_rx_ring_off = rx_ring_off;
    next_int_enable = int_enable;
    next_phase = phase;
    next_tx_ring = tx_ring_enabled && !tx_ring_off;
    next_rx_ring = rx_ring_enabled && !rx_ring_off;
    next_int_flag = indication_interrupt_flag;
    next_ring_reset = 1'b0;
    next_retx = 1'b0;
    next_discard = 1'b0;
    next_tx_abort = 1'b0;
    next_swrst_cnt = (swrst_cnt != 3'h0) ? swrst_cnt - 3'h1 : 3'h0;
    if (transparent_req && phase != LPX_STOPPED)
    begin
      next_phase = LPX_TRANSPARENT;
    end
    if (wr_fire && aw_addr == LPX_ADDR_CMD_STATUS)
    begin
      if (w_strb[1])
      begin
        if (w_data[LPX_BIT_CONFLICT])
        begin
          next_user_cmd_conflict_flag = 1'b0;
        end
        next_user_cmd_param = w_data[LPX_BIT_PARAM];
        next_user_cmd_code = w_data[LPX_CODE_HI:LPX_CODE_LO];
        if (w_data[LPX_BIT_PENDING])
        begin
          next_user_cmd_pending = 1'b1;
        end
      end
      if (w_strb[0] && w_data[LPX_BIT_IND_VALID])
      begin
        next_provider_ind_valid = 1'b0;
      end
    end
    if (wr_fire && aw_addr == LPX_ADDR_CONTROL && w_strb[0])
    begin
      next_tx_ring_off = w_data[LPX_BIT_TX_OFF];
      next_rx_ring_off = w_data[LPX_BIT_RX_OFF];
      next_int_enable = w_data[LPX_BIT_INT_EN] && (phase != LPX_STOPPED);
    end
    if (wr_fire && aw_addr == LPX_ADDR_EVENT && w_strb[0] && w_data[0])
    begin
      next_int_flag = 1'b0;
    end
    // command executes the cycle after the pending flag is written
    if (user_cmd_pending)
    begin
      // a command written in this very cycle stays pending
      next_user_cmd_pending = wr_fire && (aw_addr == LPX_ADDR_CMD_STATUS) && w_strb[1] &&
                              w_data[LPX_BIT_PENDING];
      unique case (user_cmd_code)
        LPX_CMD_STOP:
        begin
          next_phase = LPX_STOPPED;
          next_tx_abort = tx_in_frame;
          next_tx_ring = 1'b0;
          next_rx_ring = 1'b0;
          next_int_enable = 1'b0;
          next_int_flag = 1'b0;
          if (user_cmd_param)
          begin
            next_swrst_cnt = LPX_SWRST_CYCLES;
          end
        end
        LPX_CMD_START:
        begin
          if (phase == LPX_STOPPED || phase == LPX_TRANSPARENT)
          begin
            next_phase = user_cmd_param ? LPX_INFO_XFER : LPX_DISCONNECTED;
            next_ring_reset = !user_cmd_param;
            next_tx_ring = !tx_ring_off;
            next_rx_ring = !rx_ring_off;
          end
          else
          begin
            next_user_cmd_conflict_flag = 1'b1;
          end
        end
        LPX_CMD_CONNECT, LPX_CMD_RESET:
        begin
          if (phase == LPX_STOPPED)
          begin
            next_user_cmd_conflict_flag = 1'b1;
          end
          else
          begin
            next_phase = LPX_INFO_XFER;
            next_retx = !user_cmd_param;
            next_discard = user_cmd_param;
          end
        end
        default:
        begin
          if (phase == LPX_STOPPED)
          begin
            next_user_cmd_conflict_flag = 1'b1;
          end
        end
      endcase
    end
    // a new indication wins over a same-cycle host clear
    if (ind_strobe && phase != LPX_STOPPED)
    begin
      next_provider_ind_valid = 1'b1;
      next_provider_ind_code = ind_code;
      next_provider_ind_reason = ind_reason;
      next_provider_ind_lost = ind_lost;
      next_int_flag = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!soft_rst_n)
    begin
      user_cmd_conflict_flag <= 1'b0;
      user_cmd_pending <= 1'b0;
      user_cmd_param <= 1'b0;
      user_cmd_code <= 5'h00;
      provider_ind_lost <= 1'b0;
      provider_ind_valid <= 1'b0;
      provider_ind_reason <= 2'h0;
      provider_ind_code <= 4'h0;
      tx_ring_off <= 1'b0;
      rx_ring_off <= 1'b0;
      int_enable <= 1'b0;
      phase <= LPX_STOPPED;
      tx_ring_enabled <= 1'b0;
      rx_ring_enabled <= 1'b0;
      indication_interrupt_flag <= 1'b0;
      ring_reset <= 1'b0;
      retransmit_unacked <= 1'b0;
      discard_unacked <= 1'b0;
      tx_abort <= 1'b0;
    end
    else
    begin
      user_cmd_conflict_flag <= next_user_cmd_conflict_flag;
      user_cmd_pending <= next_user_cmd_pending;
      user_cmd_param <= next_user_cmd_param;
      user_cmd_code <= next_user_cmd_code;
      provider_ind_lost <= next_provider_ind_lost;
      provider_ind_valid <= next_provider_ind_valid;
      provider_ind_reason <= next_provider_ind_reason;
      provider_ind_code <= next_provider_ind_code;
      tx_ring_off <= next_tx_ring_off;
      rx_ring_off <= next_rx_ring_off;
      int_enable <= next_int_enable;
      phase <= next_phase;
      tx_ring_enabled <= next_tx_ring;
      rx_ring_enabled <= next_rx_ring;
      indication_interrupt_flag <= next_int_flag;
      ring_reset <= next_ring_reset;
      retransmit_unacked <= next_retx;
      discard_unacked <= next_discard;
      tx_abort <= next_tx_abort;
    end
  end

  // software reset timer survives its own reset, cleared only by the bus reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      swrst_cnt <= 3'h0;
      soft_reset <= 1'b0;
      link_phase <= 2'b00;
      dma_halt <= 1'b1;
      tx_force_ones <= 1'b1;
      rx_ignore <= 1'b1;
    end
    else
    begin
      swrst_cnt <= next_swrst_cnt;
      soft_reset <= (next_swrst_cnt != 3'h0);
      link_phase <= next_phase;
      dma_halt <= (next_phase == LPX_STOPPED);
      tx_force_ones <= (next_phase == LPX_STOPPED);
      rx_ignore <= (next_phase == LPX_STOPPED);
    end
  end
endmodule

// >>> bench/lpx_primitive_exchange_sva.sv
`timescale 1ns/1ps
module lpx_primitive_exchange_sva
  import lpx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ind_strobe,
  input wire logic tx_in_frame,
  input wire logic [1:0] link_phase,
  input wire logic dma_halt,
  input wire logic tx_force_ones,
  input wire logic tx_abort,
  input wire logic rx_ignore,
  input wire logic ring_reset,
  input wire logic tx_ring_enabled,
  input wire logic rx_ring_enabled,
  input wire logic retransmit_unacked,
  input wire logic discard_unacked,
  input wire logic soft_reset,
  input wire logic indication_interrupt_flag
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_swrst_hold;
    soft_reset [*4] ##1 !soft_reset;
  endsequence
  sequence s_start_from;
    $past(link_phase) == LPX_STOPPED || $past(link_phase) == LPX_TRANSPARENT;
  endsequence
  chk_stop_idle: assert property ((link_phase == LPX_STOPPED) == (dma_halt && tx_force_ones && rx_ignore))
    else $error("halt outputs disagree with stopped phase");
  chk_abort_frame: assert property (tx_abort |-> $past(tx_in_frame) && link_phase == LPX_STOPPED ##1 !tx_abort)
    else $error("frame abort without stop in frame");
  chk_swrst_len: assert property ($rose(soft_reset) |-> s_swrst_hold)
    else $error("software reset length wrong");
  chk_start_phase: assert property (ring_reset |-> link_phase == LPX_DISCONNECTED and s_start_from)
    else $error("ring reset outside a legal start");
  chk_ring_pulse: assert property (ring_reset |=> !ring_reset)
    else $error("ring reset longer than one cycle");
  chk_rings_stopped: assert property (link_phase == LPX_STOPPED |-> !tx_ring_enabled && !rx_ring_enabled)
    else $error("ring enabled while stopped");
  chk_unacked_excl: assert property (retransmit_unacked |-> !discard_unacked && link_phase != LPX_STOPPED)
    else $error("retransmit and discard clash");
  chk_ind_flag: assert property (ind_strobe && link_phase != LPX_STOPPED && !soft_reset |=> indication_interrupt_flag)
    else $error("indication did not raise flag");
  chk_flag_cause: assert property ($rose(indication_interrupt_flag) |-> $past(ind_strobe))
    else $error("indication flag rose without indication");
endmodule
bind lpx_primitive_exchange lpx_primitive_exchange_sva chk (.aclk, .aresetn, .ind_strobe, .tx_in_frame, .link_phase,
  .dma_halt, .tx_force_ones, .tx_abort, .rx_ignore, .ring_reset, .tx_ring_enabled, .rx_ring_enabled,
  .retransmit_unacked, .discard_unacked, .soft_reset, .indication_interrupt_flag);

// >>> bench/lpx_primitive_exchange_test.sv
`timescale 1ns/1ps
module lpx_primitive_exchange_test;
  import lpx_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, ind_code = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
  logic ind_strobe = 0, ind_lost = 0, transparent_req = 0, tx_in_frame = 0;
  logic [1:0] ind_reason = 2'h0, s_axi_bresp, s_axi_rresp, link_phase;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dma_halt, tx_force_ones, tx_abort;
  logic rx_ignore, ring_reset, tx_ring_enabled, rx_ring_enabled, retransmit_unacked, discard_unacked, soft_reset;
  logic indication_interrupt_flag;
  int mismatches = 0, checked = 0, n_retx = 0, n_disc = 0, n_abort = 0, e_retx = 0, e_disc = 0;
  integer seed = 32'h52DD4020;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  lpx_primitive_exchange DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ind_strobe,
    .ind_code, .ind_reason, .ind_lost, .transparent_req, .tx_in_frame, .link_phase, .dma_halt, .tx_force_ones,
    .tx_abort, .rx_ignore, .ring_reset, .tx_ring_enabled, .rx_ring_enabled, .retransmit_unacked,
    .discard_unacked, .soft_reset, .indication_interrupt_flag);
  initial forever #5 aclk = ~aclk;
  task test_done;
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    cmp_data({30'h0, got}, {30'h0, exp});
  endtask
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 60)
    begin
      mismatches++;
      test_done;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er = LPX_RESP_OKAY);
    int n;
    n = 0;
    bq.push_back(er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do
    begin
      tick(n);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
    end
    while (!s_axi_bvalid);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    rq.push_back({er, m, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do
    begin
      tick(n);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
    end
    while (!s_axi_rvalid);
  endtask
  task automatic cmd(input logic [4:0] c, input logic p);
    wr(LPX_ADDR_CMD_STATUS, {17'h0, 1'b1, p, c, 8'h00});
    repeat (3) @(posedge aclk);
  endtask
  // results are compared in arrival order against the noted expectations
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
    begin
      cmp_data(s_axi_rdata & rq[0][63:32], rq[0][31:0]);
      cmp_resp(s_axi_rresp, rq[0][65:64]);
      void'(rq.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
      cmp_resp(s_axi_bresp, bq.pop_front());
    if (retransmit_unacked) n_retx++;
    if (discard_unacked) n_disc++;
    if (tx_abort) n_abort++;
  end
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rd(LPX_ADDR_CMD_STATUS, 32'h0, 32'hFFFF);
    rd(LPX_ADDR_PHASE, 32'h0, 32'h33);
    cmd(LPX_CMD_CONNECT, 1'b0);
    rd(LPX_ADDR_CMD_STATUS, 32'h8000, 32'hC000);
    rd(LPX_ADDR_PHASE, 32'h0, 32'h3);
    wr(LPX_ADDR_CMD_STATUS, 32'h0);
    rd(LPX_ADDR_CMD_STATUS, 32'h8000, 32'h8000);
    wr(LPX_ADDR_CMD_STATUS, 32'h8000);
    rd(LPX_ADDR_CMD_STATUS, 32'h0, 32'h8000);
    wr(LPX_ADDR_CONTROL, 32'h1);
    cmd(LPX_CMD_START, 1'b0);
    rd(LPX_ADDR_PHASE, 32'h21, 32'h33);
    cmd(LPX_CMD_START, 1'b0);
    rd(LPX_ADDR_CMD_STATUS, 32'h8000, 32'hC000);
    rd(LPX_ADDR_PHASE, 32'h1, 32'h3);
    wr(LPX_ADDR_CMD_STATUS, 32'h8000);
    for (int i = 0; i < 4; i++)
    begin
      r = $random(seed);
      cmd(i[0] ? LPX_CMD_RESET : LPX_CMD_CONNECT, r[0]);
      if (r[0]) e_disc++;
      else e_retx++;
      rd(LPX_ADDR_CMD_STATUS, 32'h0, 32'hC000);
    end
    for (int i = 0; i < 6; i++)
    begin
      r = $random(seed);
      ind_strobe <= 1;
      ind_code <= r[3:0];
      ind_reason <= r[5:4];
      ind_lost <= r[6];
      @(posedge aclk);
      ind_strobe <= 0;
      @(posedge aclk);
      rd(LPX_ADDR_CMD_STATUS, {24'h0, r[6], 1'b1, r[5:0]}, 32'hFF);
      rd(LPX_ADDR_EVENT, 32'h1, 32'h1);
      wr(LPX_ADDR_CMD_STATUS, 32'h40);
      rd(LPX_ADDR_CMD_STATUS, 32'h0, 32'h40);
      wr(LPX_ADDR_EVENT, 32'h1);
      rd(LPX_ADDR_EVENT, 32'h0, 32'h1);
    end
    transparent_req <= 1;
    @(posedge aclk);
    transparent_req <= 0;
    repeat (2) @(posedge aclk);
    rd(LPX_ADDR_PHASE, 32'h2, 32'h3);
    cmd(LPX_CMD_START, 1'b1);
    rd(LPX_ADDR_PHASE, 32'h3, 32'h3);
    tx_in_frame <= 1;
    cmd(LPX_CMD_STOP, 1'b0);
    tx_in_frame <= 0;
    rd(LPX_ADDR_PHASE, 32'h0, 32'h33);
    wr(4'h6, 32'h1, LPX_RESP_SLVERR);
    rd(4'h6, 32'h0, 32'hFFFFFFFF, LPX_RESP_SLVERR);
    wr(LPX_ADDR_CONTROL, 32'h2);
    cmd(LPX_CMD_START, 1'b0);
    cmd(LPX_CMD_START, 1'b0);
    cmd(LPX_CMD_STOP, 1'b1);
    repeat (6) @(posedge aclk);
    rd(LPX_ADDR_CMD_STATUS, 32'h0, 32'hFFFF);
    rd(LPX_ADDR_CONTROL, 32'h0, 32'h7);
    rd(LPX_ADDR_PHASE, 32'h0, 32'h33);
    cmd(5'h03, 1'b0);
    rd(LPX_ADDR_CMD_STATUS, 32'h8000, 32'hC000);
    cmp_data(n_retx, e_retx);
    cmp_data(n_disc, e_disc);
    cmp_data(n_abort, 32'h1);
    test_done;
  end
endmodule
